// ---- design/serial_ctrl_consts.svh ----
// offsets, reset values, write mask and timing counts of the serial controller
`ifndef SERIAL_CTRL_CONSTS_SVH
`define SERIAL_CTRL_CONSTS_SVH
`define OFF_CTRL_ONE      8'h00
`define OFF_CTRL_TWO      8'h04
`define OFF_CTRL_THREE    8'h08
`define OFF_STATUS_ONE    8'h0c
`define OFF_DATA          8'h10
`define OFF_BAUD          8'h14
`define OFF_BREAK_CTRL    8'h18
`define RST_CTRL_ONE      8'h00
`define RST_CTRL_TWO      8'h00
`define RST_CTRL_THREE    8'h00
`define RST_BAUD          8'h00
`define RST_STATUS_ONE    8'hc0
`define CTRL3_WR_MASK     8'h4f
`define RT_PER_BIT        4'hf
`define RT_SAMPLE_A       4'h8
`define RT_SAMPLE_B       4'h9
`define RT_DECIDE         4'ha
`define FRAME_BASE_BITS   4'ha
`endif

// ---- design/serial_ctrl_pkg.sv ----
// types shared by the serial controller
package serial_ctrl_pkg;
	typedef struct packed {
		logic loop_sel;   // internal_loopback_select
		logic module_enable;
		logic tx_polarity_invert;
		logic long_char;  // 9-bit characters
		logic addr_wake;  // address-mark wakeup
		logic idle_count_start_select;
		logic parity_enable;
		logic parity_odd_select;
	} ctrl_one_t;
	typedef struct packed {
		logic tx_empty_irq_enable;
		logic tx_complete_irq_enable;
		logic rx_full_irq_enable;
		logic idle_irq_enable;
		logic tx_enable;
		logic rx_enable;
		logic rx_standby;
		logic spare;
	} ctrl_two_t;
	typedef struct packed {
		logic rx_bit8;
		logic tx_bit8;
		logic [1:0] spare;
		logic overrun_irq_enable;
		logic noise_irq_enable;
		logic framing_irq_enable;
		logic parity_irq_enable;
	} ctrl_three_t;
	typedef struct packed {
		logic tx_empty_flag;
		logic tx_complete_flag;
		logic rx_full_flag;
		logic idle_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_error_flag;
		logic parity_error_flag;
	} status_one_t;
	typedef enum logic {RX_IDLE, RX_BITS} rx_state_t;
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage

// ---- design/serial_ctrl.sv ----
// asynchronous serial controller: apb registers, error flags, pin takeover
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "serial_ctrl_consts.svh"

module serial_ctrl
	import serial_ctrl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        debug_break_state,
	input  wire logic        stop_mode,
	input  wire logic        wait_mode,
	input  wire logic        rx_pin_in,
	input  wire logic        dir_bit_tx_pin,
	input  wire logic        dir_bit_rx_pin,
	input  wire logic        port_data_tx,
	input  wire logic        port_data_rx,
	output logic             tx_pin_out,
	output logic             tx_pin_oe,
	output logic             rx_pin_out,
	output logic             rx_pin_oe,
	output logic             error_irq,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             cpu_wake
);
	ctrl_one_t   ctrl_one_reg;
	ctrl_two_t   ctrl_two_reg;
	ctrl_three_t ctrl_three_reg;
	status_one_t status_reg, status_next;
	logic [7:0]  baud_reg;
	logic        break_clear_permit_reg;
	logic [7:0]  rx_data_reg;
	logic [8:0]  tx_buf_reg;
	logic        rx_arm_reg, tx_arm_reg;
	logic        rx_meta_reg, rx_sync_reg;
	logic [7:0]  baud_cnt_reg;
	logic [3:0]  tx_rt_reg, rx_rt_reg, idle_cnt_reg;
	logic [3:0]  tx_left_reg, rx_idx_reg;
	logic [10:0] tx_shift_reg, rx_shift_reg;
	logic        samp_a_reg, samp_b_reg, rx_noise_reg, idle_seen_reg;
	tx_state_t   tx_state_reg;
	rx_state_t   rx_state_reg;
	// fold parity into the most significant data position: bit 8 for 9-bit characters, bit 7 otherwise
	function automatic logic [8:0] with_parity(input logic [8:0] d, input logic m, input logic odd);
		logic [8:0] r;
		r = d;
		if (m) begin
			r[8] = (^d[7:0]) ^ odd;
		end else begin
			r[7] = (^d[6:0]) ^ odd;
		end
		return r;
	endfunction

	// majority of three samples
	function automatic logic vote(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction
	// bus decode
	wire        setup_ph   = psel & ~penable;
	wire        access_ph  = psel & penable;
	wire        hit_c1     = paddr == `OFF_CTRL_ONE;
	wire        hit_c2     = paddr == `OFF_CTRL_TWO;
	wire        hit_c3     = paddr == `OFF_CTRL_THREE;
	wire        hit_st     = paddr == `OFF_STATUS_ONE;
	wire        hit_dat    = paddr == `OFF_DATA;
	wire        hit_baud   = paddr == `OFF_BAUD;
	wire        hit_brk    = paddr == `OFF_BREAK_CTRL;
	wire        mapped     = hit_c1 | hit_c2 | hit_c3 | hit_st | hit_dat | hit_baud | hit_brk;
	wire        wr_ok      = access_ph & pwrite & mapped;
	wire        rd_ok      = access_ph & ~pwrite & mapped;
	// flags may only be cleared outside break, or inside it with the permit set
	wire        clr_allow  = ~debug_break_state | break_clear_permit_reg;
	wire        en         = ctrl_one_reg.module_enable;
	// stop mode gates every tick so nothing advances and nothing is lost
	wire        run        = en & ~stop_mode;
	wire        samp_tick  = run & (baud_cnt_reg == baud_reg);
	wire        tx_tick    = samp_tick & (tx_rt_reg == `RT_PER_BIT);
	wire        long_c     = ctrl_one_reg.long_char;
	wire [3:0]  frame_bits = `FRAME_BASE_BITS + {3'h0, long_c};
	wire [3:0]  last_idx   = frame_bits - 4'h1;
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;
	// pins: the module takes both pins while enabled, otherwise port logic owns them
	wire tx_level = ctrl_one_reg.tx_polarity_invert ^ tx_shift_reg[0];
	assign tx_pin_out = en ? tx_level : port_data_tx;
	assign tx_pin_oe  = en ? 1'b1 : dir_bit_tx_pin;
	assign rx_pin_out = port_data_rx;
	assign rx_pin_oe  = en ? 1'b0 : dir_bit_rx_pin;
	// loop mode relies on software enabling both directions
	wire rx_line = ctrl_one_reg.loop_sel ? tx_level : rx_sync_reg;
	// interrupt requests; transmitter requests vanish while disabled
	wire err_any = (status_reg.overrun_flag & ctrl_three_reg.overrun_irq_enable)
		| (status_reg.noise_flag & ctrl_three_reg.noise_irq_enable)
		| (status_reg.framing_error_flag & ctrl_three_reg.framing_irq_enable)
		| (status_reg.parity_error_flag & ctrl_three_reg.parity_irq_enable);
	assign error_irq = err_any;
	assign tx_irq    = en & ((status_reg.tx_empty_flag & ctrl_two_reg.tx_empty_irq_enable)
		| (status_reg.tx_complete_flag & ctrl_two_reg.tx_complete_irq_enable));
	assign rx_irq    = ~ctrl_two_reg.rx_standby & ((status_reg.rx_full_flag & ctrl_two_reg.rx_full_irq_enable)
		| (status_reg.idle_flag & ctrl_two_reg.idle_irq_enable));
	assign cpu_wake  = wait_mode & (error_irq | tx_irq | rx_irq);
	// receiver frame decode at the stop-bit decision
	wire       rx_bit     = vote(samp_a_reg, samp_b_reg, rx_line);
	wire       rx_noisy   = ~((samp_a_reg == samp_b_reg) && (samp_b_reg == rx_line));
	wire       rx_decide  = samp_tick & (rx_state_reg == RX_BITS) & (rx_rt_reg == `RT_DECIDE);
	wire       false_strt = rx_decide & (rx_idx_reg == 4'h0) & rx_bit;
	wire       rx_last    = rx_decide & (rx_idx_reg == last_idx);
	wire [8:0] rx_payload = long_c ? rx_shift_reg[9:1] : {rx_shift_reg[8], rx_shift_reg[8:1]};
	wire       rx_msb     = long_c ? rx_shift_reg[9] : rx_shift_reg[8];
	wire       par_sum    = long_c ? ^rx_shift_reg[9:1] : ^rx_shift_reg[8:1];
	wire       par_bad    = ctrl_one_reg.parity_enable & (par_sum != ctrl_one_reg.parity_odd_select);
	wire       addr_mark  = ctrl_one_reg.addr_wake & rx_msb;
	wire       rx_deliver = rx_last & ctrl_two_reg.rx_enable & (~ctrl_two_reg.rx_standby | addr_mark);
	wire       idle_hit   = ~idle_seen_reg & (idle_cnt_reg >= frame_bits) & ctrl_two_reg.rx_enable;
	wire       idle_wake  = idle_hit & ctrl_two_reg.rx_standby & ~ctrl_one_reg.addr_wake;
	wire       tx_load    = tx_tick & (tx_state_reg == TX_IDLE) & ctrl_two_reg.tx_enable
		& ~status_reg.tx_empty_flag;
	// parity replaces the top data bit only when enabled
	wire [8:0] tx_payload = ctrl_one_reg.parity_enable
		? with_parity(tx_buf_reg, long_c, ctrl_one_reg.parity_odd_select) : tx_buf_reg;
	// two-step clears: status read arms, data access completes
	wire st_read   = rd_ok & hit_st & clr_allow;
	wire dat_read  = rd_ok & hit_dat;
	wire dat_write = wr_ok & hit_dat;
	wire rx_clear  = dat_read & rx_arm_reg & clr_allow;
	wire tx_clear  = dat_write & tx_arm_reg & clr_allow;
	// status next value: clears first, sets after so a coincident event wins
	always_comb begin
		status_next = status_reg;
		if (rx_clear) begin
			status_next[5:0] = 6'h00; // receiver flags
		end
		if (tx_clear) begin
			status_next[7:6] = 2'b00;
		end
		if (rx_deliver) begin
			if (status_reg.rx_full_flag && !rx_clear) begin
				status_next.overrun_flag = 1'b1;
			end else begin
				status_next.rx_full_flag       = 1'b1;
				status_next.framing_error_flag = ~rx_bit;
				status_next.noise_flag         = rx_noise_reg | rx_noisy;
				status_next.parity_error_flag  = par_bad;
			end
		end
		if (idle_hit && !idle_wake) begin
			status_next.idle_flag = 1'b1;
		end
		if (tx_load) begin
			status_next.tx_empty_flag = 1'b1;
		end
		if (tx_state_reg == TX_IDLE && status_reg.tx_empty_flag && !tx_clear) begin
			status_next.tx_complete_flag = 1'b1;
		end
		if (!en) begin
			status_next[7:6] = 2'b11;
		end
	end

	// read data, registered in the setup phase so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata <= 32'h0000_0000;
			if (hit_c1)   prdata[7:0] <= ctrl_one_reg;
			if (hit_c2)   prdata[7:0] <= ctrl_two_reg;
			if (hit_c3)   prdata[7:0] <= ctrl_three_reg;
			if (hit_st)   prdata[7:0] <= status_reg;
			if (hit_dat)  prdata[7:0] <= rx_data_reg;
			if (hit_baud) prdata[7:0] <= baud_reg;
			if (hit_brk)  prdata[0]   <= break_clear_permit_reg;
		end
	end
	// software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_one_reg           <= `RST_CTRL_ONE;
			ctrl_two_reg           <= `RST_CTRL_TWO;
			ctrl_three_reg         <= `RST_CTRL_THREE;
			baud_reg               <= `RST_BAUD;
			break_clear_permit_reg <= 1'b0;
			tx_buf_reg             <= 9'h000;
		end else begin
			if (wr_ok && hit_c1) ctrl_one_reg <= pwdata[7:0];
			if (wr_ok && hit_c3) begin
				ctrl_three_reg <= (pwdata[7:0] & `CTRL3_WR_MASK) | (ctrl_three_reg & ~`CTRL3_WR_MASK);
			end
			if (wr_ok && hit_baud) baud_reg <= pwdata[7:0];
			if (wr_ok && hit_brk) break_clear_permit_reg <= pwdata[0];
			if (dat_write) tx_buf_reg <= {ctrl_three_reg.tx_bit8, pwdata[7:0]};
			// tx_enable and rx_enable are writable only with the module on
			if (wr_ok && hit_c2) begin
				ctrl_two_reg[7:4] <= pwdata[7:4];
				ctrl_two_reg.rx_standby <= pwdata[1];
				if (en) begin
					ctrl_two_reg.tx_enable <= pwdata[3];
					ctrl_two_reg.rx_enable <= pwdata[2];
				end
			end else if ((rx_deliver && addr_mark) || idle_wake) begin
				ctrl_two_reg.rx_standby <= 1'b0;
			end
			if (rx_deliver && (!status_reg.rx_full_flag || rx_clear)) begin
				ctrl_three_reg.rx_bit8 <= rx_payload[8];
			end
		end
	end
	// flags, arming and received data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg  <= `RST_STATUS_ONE;
			rx_arm_reg  <= 1'b0;
			tx_arm_reg  <= 1'b0;
			rx_data_reg <= 8'h00;
		end else begin
			status_reg <= status_next;
			// an arm taken before a protected break survives it for the second step
			if (st_read) begin
				rx_arm_reg <= |status_reg[5:0];
				tx_arm_reg <= status_reg.tx_empty_flag;
			end else begin
				if (rx_clear) rx_arm_reg <= 1'b0;
				if (tx_clear) tx_arm_reg <= 1'b0;
			end
			if (rx_deliver && (!status_reg.rx_full_flag || rx_clear)) begin
				rx_data_reg <= rx_payload[7:0];
			end
		end
	end
	// receive pin synchroniser and sample-rate divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_reg  <= 1'b1;
			rx_sync_reg  <= 1'b1;
			baud_cnt_reg <= 8'h00;
		end else begin
			rx_meta_reg <= rx_pin_in;
			rx_sync_reg <= rx_meta_reg;
			if (!en) baud_cnt_reg <= 8'h00;
			else if (samp_tick) baud_cnt_reg <= 8'h00;
			else if (run) baud_cnt_reg <= baud_cnt_reg + 8'h01;
		end
	end

	// transmitter: one bit per sixteen sample ticks, lsb first, line idles high unless tx_polarity_invert is set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_rt_reg    <= 4'h0;
			tx_left_reg  <= 4'h0;
		end else if (!en) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_rt_reg    <= 4'h0;
		end else begin
			if (samp_tick) tx_rt_reg <= tx_rt_reg + 4'h1;
			case (tx_state_reg)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift_reg <= long_c ? {1'b1, tx_payload, 1'b0}
							: {2'b11, tx_payload[7:0], 1'b0};
						tx_left_reg  <= frame_bits;
						tx_state_reg <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tx_tick) begin
						tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
						tx_left_reg  <= tx_left_reg - 4'h1;
						if (tx_left_reg == 4'h1) tx_state_reg <= TX_IDLE;
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// receiver: sixteen sample ticks per bit, three votes around mid-bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_reg  <= RX_IDLE;
			rx_rt_reg     <= 4'h0;
			rx_idx_reg    <= 4'h0;
			rx_shift_reg  <= 11'h000;
			samp_a_reg    <= 1'b1;
			samp_b_reg    <= 1'b1;
			rx_noise_reg  <= 1'b0;
			idle_cnt_reg  <= 4'h0;
			idle_seen_reg <= 1'b0;
		end else if (!en) begin
			rx_state_reg <= RX_IDLE;
			idle_cnt_reg <= 4'h0;
		end else if (samp_tick) begin
			rx_rt_reg <= rx_rt_reg + 4'h1;
			if (idle_hit) idle_seen_reg <= 1'b1;
			case (rx_state_reg)
				RX_IDLE: begin
					if (!rx_line) begin
						rx_state_reg  <= RX_BITS;
						rx_rt_reg     <= 4'h2;
						rx_idx_reg    <= 4'h0;
						rx_noise_reg  <= 1'b0;
						idle_cnt_reg  <= 4'h0;
						idle_seen_reg <= 1'b0;
					end else if (rx_rt_reg == `RT_PER_BIT && idle_cnt_reg != 4'hf) begin
						idle_cnt_reg <= idle_cnt_reg + 4'h1;
					end
				end
				RX_BITS: begin
					if (rx_rt_reg == `RT_SAMPLE_A) samp_a_reg <= rx_line;
					if (rx_rt_reg == `RT_SAMPLE_B) samp_b_reg <= rx_line;
					if (rx_rt_reg == `RT_PER_BIT) rx_idx_reg <= rx_idx_reg + 4'h1;
					if (rx_decide) begin
						rx_shift_reg[rx_idx_reg] <= rx_bit;
						rx_noise_reg <= rx_noise_reg | rx_noisy;
						// count ones from the start bit, or only from the stop bit on
						if (!ctrl_one_reg.idle_count_start_select && rx_idx_reg != 4'h0) begin
							idle_cnt_reg <= rx_bit ? idle_cnt_reg + 4'h1 : 4'h0;
						end
						if (false_strt) rx_state_reg <= RX_IDLE;
						if (rx_last) begin
							rx_state_reg <= RX_IDLE;
							rx_rt_reg    <= 4'h0;
							if (ctrl_one_reg.idle_count_start_select) idle_cnt_reg <= 4'h0;
						end
					end
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end
endmodule

// ---- verification/serial_far_end.sv ----
// far-end serial partner: sends frames into the receive pin, captures transmit frames
`timescale 1ns/1ns
module serial_far_end (
	input  wire logic pclk,
	input  wire logic tx_line,
	output logic      rx_line
);
	int bit_t = 16;

	// line idles high between frames, as a real remote end leaves it
	initial rx_line = 1'b1;

	// start, data lsb first, stop; bit g gets a two-cycle glitch mid-bit
	task automatic send(input logic [8:0] d, input int n, input logic s, input int g);
		logic b;
		for (int i = 0; i < n + 2; i++) begin
			b = (i == 0) ? 1'b0 : (i == n + 1) ? s : d[i-1];
			for (int c = 0; c < bit_t; c++) begin
				@(posedge pclk) rx_line <= (i == g && (c == 8 || c == 9)) ? ~b : b;
			end
		end
		@(posedge pclk) rx_line <= 1'b1;
		repeat (24) @(posedge pclk);
	endtask

	// raw levels taken mid-bit, so inverted start and stop show as sent
	task automatic recv(input logic inv, input int n, output logic [10:0] f);
		f = '0;
		while (tx_line === ~inv) @(posedge pclk);
		repeat (bit_t / 2) @(posedge pclk);
		for (int i = 0; i < n + 2; i++) begin
			f[i] = tx_line;
			repeat (bit_t) @(posedge pclk);
		end
	endtask
endmodule

// ---- verification/serial_ctrl_asserts.sv ----
// port-level assertions for the serial controller
`timescale 1ns/1ns
module serial_ctrl_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        stop_mode,
	input wire logic        wait_mode,
	input wire logic        dir_bit_tx_pin,
	input wire logic        port_data_tx,
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe,
	input wire logic        rx_pin_oe,
	input wire logic        error_irq,
	input wire logic        tx_irq,
	input wire logic        rx_irq,
	input wire logic        cpu_wake
);
	logic       en_q;
	logic [3:0] ie_q;
	wire        wr_go = psel && penable && pwrite;

	// shadow of enable and error enables; the flags stay hidden behind the ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0;
			ie_q <= 4'h0;
		end else if (wr_go && paddr == 8'h00) begin
			en_q <= pwdata[6];
		end else if (wr_go && paddr == 8'h08) begin
			ie_q <= pwdata[3:0];
		end
	end

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	tx_own_a: assert property (en_q |-> tx_pin_oe)
		else $error("transmit pin not driven while enabled");
	rx_own_a: assert property (en_q |-> !rx_pin_oe)
		else $error("receive pin driven while enabled");
	port_pass_a: assert property (!en_q |-> tx_pin_oe == dir_bit_tx_pin && tx_pin_out == port_data_tx)
		else $error("port setting not passed while disabled");
	tx_irq_off_a: assert property (!en_q |-> !tx_irq)
		else $error("transmit request while disabled");
	err_gate_a: assert property (ie_q == 4'h0 |-> !error_irq)
		else $error("error request with all enables clear");
	wake_join_a: assert property (cpu_wake == (wait_mode && (error_irq || tx_irq || rx_irq)))
		else $error("wake output disagrees with requests");
	stop_hold_a: assert property ((stop_mode && en_q) [*2] |-> $stable(tx_pin_out))
		else $error("transmit pin moved in stop mode");
	unmapped_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
		else $error("no error on unmapped access");
	rdata_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
		else $error("read data upper bits or error data wrong");

	cover property ((stop_mode && en_q) [*3]);
	cover property (wait_mode && cpu_wake);
	cover property (psel && penable && pslverr);
endmodule

// ---- verification/serial_ctrl_tb_top.sv ----
// self-checking bench for the serial controller
`timescale 1ns/1ns
module serial_ctrl_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin_in;
	logic [7:0]  paddr, v;
	logic [31:0] pwdata, prdata;
	logic        debug_break_state, stop_mode, wait_mode, tx_pin_out, tx_pin_oe, rx_pin_out, rx_pin_oe;
	logic        dir_bit_tx_pin, dir_bit_rx_pin, port_data_tx, port_data_rx, error_irq, tx_irq, rx_irq, cpu_wake;
	logic [10:0] f;
	int          err_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	typedef struct packed {
		logic [7:0] c1;
		logic [8:0] d;
		logic       s;
		logic [7:0] xd;
		logic [7:0] xs;
	} row_t;
	row_t r;
	// control one, frame data, stop level, expected data and receive-full plus error flags
	row_t rows [9] = '{
		'{8'h4c, 9'h0a5, 1'b1, 8'ha5, 8'h20},
		'{8'h40, 9'h03c, 1'b0, 8'h3c, 8'h22},
		'{8'h42, 9'h003, 1'b1, 8'h03, 8'h20},
		'{8'h42, 9'h083, 1'b1, 8'h83, 8'h21},
		'{8'h43, 9'h083, 1'b1, 8'h83, 8'h20},
		'{8'h43, 9'h003, 1'b1, 8'h03, 8'h21},
		'{8'h50, 9'h1a5, 1'b1, 8'ha5, 8'h20},
		'{8'h50, 9'h1a5, 1'b0, 8'ha5, 8'h22},
		'{8'h52, 9'h100, 1'b1, 8'h00, 8'h21}
	};

	serial_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.debug_break_state, .stop_mode, .wait_mode, .rx_pin_in, .dir_bit_tx_pin, .dir_bit_rx_pin,
		.port_data_tx, .port_data_rx, .tx_pin_out, .tx_pin_oe, .rx_pin_out, .rx_pin_oe, .error_irq,
		.tx_irq, .rx_irq, .cpu_wake);
	serial_far_end far (.pclk, .tx_line(tx_pin_out), .rx_line(rx_pin_in));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic end_of_test;
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// apb transfer; no wait count assumed, the cycle ceiling cuts a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		v = prdata[7:0];
		psel    <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	initial begin
		{psel, penable, pwrite, debug_break_state, stop_mode, wait_mode, presetn} = '0;
		{dir_bit_tx_pin, dir_bit_rx_pin, port_data_tx, port_data_rx, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		{dir_bit_tx_pin, dir_bit_rx_pin, port_data_tx, port_data_rx} <= 4'hf;
		xfer(0, 8'h00, 0);
		chk("ctrl1_rst", v, 8'h00);
		xfer(0, 8'h0c, 0);
		chk("status_rst", v, 8'hc0);
		chk("rx_pin_out", rx_pin_out, 1'b1);
		foreach (rows[i]) begin
			r = rows[i];
			xfer(1, 8'h00, r.c1);
			xfer(1, 8'h04, 8'h0c);
			xfer(0, 8'h00, 0);
			chk("ctrl1", v, r.c1);
			far.send(r.d, 8 + r.c1[4], r.s, 99);
			xfer(0, 8'h0c, 0);
			chk("status", v & 8'h2f, r.xs);
			xfer(0, 8'h10, 0);
			chk("data", v, r.xd);
		end
		// overrun, error request gating, wake
		xfer(1, 8'h00, 8'h40);
		far.send(9'h011, 8, 1'b1, 99);
		far.send(9'h022, 8, 1'b1, 99);
		chk("err_off", error_irq, 1'b0);
		xfer(1, 8'h08, 8'h08);
		chk("err_on", error_irq, 1'b1);
		@(posedge pclk) wait_mode <= 1'b1;
		@(posedge pclk) wait_mode <= 1'b1;
		#1 chk("wake", cpu_wake, 1'b1);
		xfer(0, 8'h0c, 0);
		chk("overrun", v & 8'h2f, 8'h28);
		xfer(0, 8'h10, 0);
		chk("kept", v, 8'h11);
		chk("err_clr", error_irq, 1'b0);
		wait_mode <= 1'b0;
		xfer(1, 8'h08, 8'h04);
		far.send(9'h0ff, 8, 1'b1, 3);
		chk("noise_irq", error_irq, 1'b1);
		xfer(0, 8'h0c, 0);
		chk("noise", v & 8'h24, 8'h24);
		xfer(0, 8'h10, 0);
		// debug break with and without clear permit
		xfer(1, 8'h18, 8'h00);
		far.send(9'h033, 8, 1'b1, 99);
		xfer(0, 8'h0c, 0);
		@(posedge pclk) debug_break_state <= 1'b1;
		xfer(0, 8'h10, 0);
		xfer(0, 8'h0c, 0);
		chk("brk_hold", v & 8'h20, 8'h20);
		@(posedge pclk) debug_break_state <= 1'b0;
		xfer(0, 8'h10, 0);
		xfer(0, 8'h0c, 0);
		chk("brk_after", v & 8'h20, 8'h00);
		xfer(1, 8'h18, 8'h01);
		far.send(9'h044, 8, 1'b1, 99);
		@(posedge pclk) debug_break_state <= 1'b1;
		xfer(0, 8'h0c, 0);
		xfer(0, 8'h10, 0);
		@(posedge pclk) debug_break_state <= 1'b0;
		xfer(0, 8'h0c, 0);
		chk("brk_clear", v & 8'h20, 8'h00);
		// transmit frames: plain, inverted, 9-bit odd parity
		xfer(1, 8'h04, 8'h0c);
		xfer(1, 8'h10, 8'h5a);
		far.recv(1'b0, 8, f);
		chk("frame", f, 11'h2b4);
		xfer(1, 8'h00, 8'h60);
		chk("idle_inv", tx_pin_out, 1'b0);
		xfer(0, 8'h0c, 0);
		xfer(1, 8'h10, 8'ha5);
		far.recv(1'b1, 8, f);
		chk("frame_inv", f, 11'h0b5);
		xfer(1, 8'h00, 8'h53);
		xfer(0, 8'h0c, 0);
		xfer(1, 8'h10, 8'h07);
		far.recv(1'b0, 9, f);
		chk("frame_par", f, 11'h40e);
		xfer(0, 8'h0c, 0);
		xfer(1, 8'h10, 8'h99);
		xfer(1, 8'h00, 8'h00);
		xfer(0, 8'h0c, 0);
		chk("tx_flags", v & 8'hc0, 8'hc0);
		// stop mode freezes a frame in flight
		xfer(1, 8'h00, 8'h40);
		xfer(1, 8'h04, 8'h0c);
		xfer(1, 8'h10, 8'h3c);
		repeat (40) @(posedge pclk);
		stop_mode <= 1'b1;
		repeat (100) @(posedge pclk);
		stop_mode <= 1'b0;
		repeat (300) @(posedge pclk);
		#1 chk("resume", tx_pin_out, 1'b1);
		xfer(0, 8'h00, 0);
		chk("ctrl_kept", v, 8'h40);
		// loop mode ignores a stuck-low receive pin
		xfer(1, 8'h00, 8'hc0);
		xfer(1, 8'h04, 8'h0c);
		@(posedge pclk) far.rx_line <= 1'b0;
		xfer(0, 8'h0c, 0);
		xfer(1, 8'h10, 8'h6e);
		repeat (250) @(posedge pclk);
		xfer(0, 8'h0c, 0);
		chk("loop_st", v & 8'h2f, 8'h20);
		xfer(0, 8'h10, 0);
		chk("loop_data", v, 8'h6e);
		@(posedge pclk) far.rx_line <= 1'b1;
		xfer(0, 8'h1c, 0);
		chk("unmapped", v, 8'h00);
		// second reset in mid-run
		xfer(1, 8'h00, 8'hff);
		@(posedge pclk) presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, 8'h00, 0);
		chk("ctrl1_rst2", v, 8'h00);
		end_of_test();
	end
endmodule

bind serial_ctrl serial_ctrl_asserts chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pslverr, .stop_mode, .wait_mode, .dir_bit_tx_pin, .port_data_tx, .tx_pin_out, .tx_pin_oe, .rx_pin_oe,
	.error_irq, .tx_irq, .rx_irq, .cpu_wake);
